//--- hdl/spsd_panel.sv
// Purpose: front-panel key handling and status view of a servo drive
// Assumes: key inputs are debounced one-cycle pulses synchronous to mclk
// Notes: parameter store and monitor content live outside this block
`timescale 1ns/1ps
module spsd_panel #(
    parameter int STARTUP_CYCLES = spsd_pkg::STARTUP_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire spsd_pkg::spsd_keys_t keys,
    input wire spsd_pkg::spsd_status_t st,
    input wire spsd_pkg::spsd_meas_t meas,
    input wire logic threshLoad,
    input wire spsd_pkg::spsd_thresh_t threshIn,
    input wire logic [spsd_pkg::VAL_W-1:0] loadValue,
    input wire logic [spsd_pkg::ALMNUM_W-1:0] alarmNumber,
    output logic displayOn,
    output spsd_pkg::spsd_mode_t mode,
    output logic editing,
    output logic [2:0] activeDigit,
    output logic [spsd_pkg::VAL_W-1:0] editValue,
    output logic [6:0] bitSegs,
    output spsd_pkg::spsd_code_t stateCode,
    output logic [spsd_pkg::ALMNUM_W-1:0] alarmShown,
    output logic alarmClearReq,
    output spsd_pkg::spsd_thresh_t thresh
);
    // ==========================================================
    // Power-up wait
    localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
    logic [CNT_W-1:0] waitCnt_r;
    logic displayOn_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            waitCnt_r <= '0;
            displayOn_r <= 1'b0;
        end else if (!displayOn_r) begin
            if (waitCnt_r == CNT_W'(STARTUP_CYCLES - 1)) begin
                displayOn_r <= 1'b1;
            end else begin
                waitCnt_r <= waitCnt_r + 1'b1;
            end
        end
    end
    assign displayOn = displayOn_r;

    // ==========================================================
    // Threshold parameters
    spsd_pkg::spsd_thresh_t thresh_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            thresh_r.speedMatchWindow <= spsd_pkg::SPEED_MATCH_DEF;
            thresh_r.positionDoneWindow <= spsd_pkg::POS_DONE_DEF;
            thresh_r.rotationSpeedThreshold <= spsd_pkg::ROT_THRESH_DEF;
            thresh_r.torquePreset <= spsd_pkg::TORQUE_PRESET_DEF;
        end else if (threshLoad) begin
            thresh_r <= threshIn;
        end
    end
    assign thresh = thresh_r;

    // ==========================================================
    // Mode selection; keys are ignored until the display is up
    spsd_pkg::spsd_mode_t mode_r;
    logic keysLive;
    assign keysLive = displayOn_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_r <= spsd_pkg::MODE_STATUS;
        end else if (keysLive && keys.mode) begin
            unique case (mode_r)
                spsd_pkg::MODE_STATUS: mode_r <= spsd_pkg::MODE_UTILITY;
                spsd_pkg::MODE_UTILITY: mode_r <= spsd_pkg::MODE_PARAM;
                spsd_pkg::MODE_PARAM: mode_r <= spsd_pkg::MODE_MONITOR;
                spsd_pkg::MODE_MONITOR: mode_r <= spsd_pkg::MODE_STATUS;
            endcase
        end
    end
    assign mode = mode_r;

    // ==========================================================
    // Value editing. The data key opens the value view from the
    // selection view; in value view it moves the active digit left.
    // Mode key leaves editing so a new mode starts clean.
    logic editing_r;
    logic [2:0] digit_r;
    logic [spsd_pkg::VAL_W-1:0] value_r;
    logic [spsd_pkg::VAL_W-1:0] step;
    logic editMode;

    assign editMode = mode_r != spsd_pkg::MODE_STATUS;
    // Step is one unit of the active decimal digit; the value wraps at the width
    always_comb begin
        unique case (digit_r)
            3'h0: step = 16'h0001;
            3'h1: step = 16'h000a;
            3'h2: step = 16'h0064;
            3'h3: step = 16'h03e8;
            default: step = 16'h2710;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            editing_r <= 1'b0;
        end else if (keysLive && keys.mode) begin
            editing_r <= 1'b0;
        end else if (keysLive && editMode && keys.dataSet && !editing_r) begin
            editing_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            digit_r <= spsd_pkg::DIGIT_FIRST;
        end else if (keysLive && (keys.mode || (keys.dataSet && !editing_r))) begin
            digit_r <= spsd_pkg::DIGIT_FIRST;
        end else if (keysLive && editing_r && keys.dataSet) begin
            digit_r <= (digit_r == spsd_pkg::DIGIT_LAST)
                ? spsd_pkg::DIGIT_FIRST : digit_r + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            value_r <= '0;
        end else if (keysLive && editMode && keys.dataSet && !editing_r) begin
            value_r <= loadValue;
        end else if (keysLive && editMode) begin
            if (keys.up && !keys.down) begin
                value_r <= value_r + step;
            end else if (keys.down && !keys.up) begin
                value_r <= value_r - step;
            end
        end
    end
    assign editing = editing_r;
    assign activeDigit = digit_r;
    assign editValue = value_r;

    // ==========================================================
    // Status view: bit-data segments
    logic [6:0] segs;

    spsd_seg_eval u_seg (
        .mclk(mclk),
        .rstn(rstn),
        .st(st),
        .meas(meas),
        .th(thresh_r),
        .segs_r(segs)
    );
    assign bitSegs = segs;

    // ==========================================================
    // Status view: state code, highest severity first
    spsd_pkg::spsd_code_t code_r;
    spsd_pkg::spsd_code_t codeNxt;
    logic [spsd_pkg::ALMNUM_W-1:0] almShown_r;

    always_comb begin
        if (st.initFail) begin
            codeNxt = spsd_pkg::CODE_INIT_FAIL;
        end else if (st.alarm && st.showAlarmNum) begin
            codeNxt = spsd_pkg::CODE_ALARM_NUM;
        end else if (st.alarm) begin
            codeNxt = spsd_pkg::CODE_ALARM;
        end else if (st.safeState) begin
            codeNxt = spsd_pkg::CODE_SAFE;
        end else if (st.quickStop) begin
            codeNxt = spsd_pkg::CODE_QUICK_STOP;
        end else if (st.fwdProhibit && st.revProhibit) begin
            codeNxt = spsd_pkg::CODE_OVERTRAVEL;
        end else if (st.fwdProhibit) begin
            codeNxt = spsd_pkg::CODE_FWD_PROHIB;
        end else if (st.revProhibit) begin
            codeNxt = spsd_pkg::CODE_REV_PROHIB;
        end else if (st.servoOn) begin
            codeNxt = spsd_pkg::CODE_RUN;
        end else if (st.servoReady) begin
            codeNxt = spsd_pkg::CODE_READY;
        end else begin
            codeNxt = spsd_pkg::CODE_SERVO_OFF;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            code_r <= spsd_pkg::CODE_SERVO_OFF;
        end else begin
            code_r <= codeNxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            almShown_r <= '0;
        end else begin
            almShown_r <= st.alarm ? alarmNumber : '0;
        end
    end
    assign stateCode = code_r;
    assign alarmShown = almShown_r;

    // ==========================================================
    // Alarm clear request, one-cycle pulse
    logic clrReq_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clrReq_r <= 1'b0;
        end else begin
            clrReq_r <= keysLive && st.alarm && keys.dataSet
                && mode_r == spsd_pkg::MODE_STATUS;
        end
    end
    assign alarmClearReq = clrReq_r;

    // ==========================================================
    // Checks
    property p_mode_wrap;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && keys.mode && mode_r == spsd_pkg::MODE_MONITOR)
            |=> mode_r == spsd_pkg::MODE_STATUS;
    endproperty
    a_mode_wrap: assert property (p_mode_wrap) else $error("mode did not wrap");

    property p_mode_step;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && keys.mode && mode_r == spsd_pkg::MODE_STATUS)
            |=> mode_r == spsd_pkg::MODE_UTILITY;
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode did not step");

    property p_up;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && editMode && keys.up && !keys.down && !keys.dataSet)
            |=> value_r == $past(value_r) + $past(step);
    endproperty
    a_up: assert property (p_up) else $error("up key did not increase");

    property p_down;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && editMode && keys.down && !keys.up && !keys.dataSet)
            |=> value_r == $past(value_r) - $past(step);
    endproperty
    a_down: assert property (p_down) else $error("down key did not decrease");

    property p_shift;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && editing_r && keys.dataSet && !keys.mode && digit_r == 3'h1)
            |=> digit_r == 3'h2;
    endproperty
    a_shift: assert property (p_shift) else $error("digit did not shift left");

    property p_startup;
        @(posedge mclk) disable iff (!rstn)
            $rose(displayOn_r) |-> mode_r == spsd_pkg::MODE_STATUS;
    endproperty
    a_startup: assert property (p_startup) else $error("did not start in status view");

    property p_clear;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && st.alarm && keys.dataSet && mode_r == spsd_pkg::MODE_STATUS)
            |=> clrReq_r ##1 !clrReq_r || (keysLive && st.alarm && keys.dataSet);
    endproperty
    a_clear: assert property (p_clear) else $error("alarm clear not requested");

    property p_code_alarm;
        @(posedge mclk) disable iff (!rstn)
            (!st.initFail && st.alarm && !st.showAlarmNum)
            |=> code_r == spsd_pkg::CODE_ALARM;
    endproperty
    a_code_alarm: assert property (p_code_alarm) else $error("alarm code not shown");

    property p_keys_early;
        @(posedge mclk) disable iff (!rstn)
            (!displayOn_r && keys.mode)
            |=> $stable(mode_r);
    endproperty
    a_keys_early: assert property (p_keys_early) else $error("mode key taken before display");

    property p_open_value;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && editMode && keys.dataSet && !keys.mode && !editing_r)
            |=> editing_r && digit_r == spsd_pkg::DIGIT_FIRST && value_r == $past(loadValue);
    endproperty
    a_open_value: assert property (p_open_value) else $error("value view not opened");

    property p_mode_close;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && keys.mode)
            |=> !editing_r && digit_r == spsd_pkg::DIGIT_FIRST;
    endproperty
    a_mode_close: assert property (p_mode_close) else $error("mode key left edit open");

    property p_up_down;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && keys.up && keys.down && !(editMode && keys.dataSet && !editing_r))
            |=> $stable(value_r);
    endproperty
    a_up_down: assert property (p_up_down) else $error("value moved on both keys");

    property p_digit_wrap;
        @(posedge mclk) disable iff (!rstn)
            (keysLive && editing_r && keys.dataSet && !keys.mode
                && digit_r == spsd_pkg::DIGIT_LAST)
            |=> digit_r == spsd_pkg::DIGIT_FIRST;
    endproperty
    a_digit_wrap: assert property (p_digit_wrap) else $error("digit did not wrap");

    property p_clear_status;
        @(posedge mclk) disable iff (!rstn)
            (mode_r != spsd_pkg::MODE_STATUS || !st.alarm)
            |=> !clrReq_r;
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear request without alarm");

    property p_code_init;
        @(posedge mclk) disable iff (!rstn)
            st.initFail
            |=> code_r == spsd_pkg::CODE_INIT_FAIL;
    endproperty
    a_code_init: assert property (p_code_init) else $error("init failure code not shown");

    property p_thresh_load;
        @(posedge mclk) disable iff (!rstn)
            threshLoad
            |=> thresh_r == $past(threshIn);
    endproperty
    a_thresh_load: assert property (p_thresh_load) else $error("thresholds not loaded");

endmodule // spsd_panel

//--- hdl/spsd_pkg.sv
// Purpose: shared constants and types for the servo panel status display
// Assumes: one clock mclk at 125 MHz, synchronous active-low reset
// Notes: speeds in rpm, position error in pulses, torque in percent of rated
package spsd_pkg;

    // ==========================================================
    // Widths
    localparam int SPEED_W = 16;
    localparam int POS_W = 32;
    localparam int VAL_W = 16;
    localparam int ALMNUM_W = 12;

    // ==========================================================
    // Reset values of threshold parameters
    localparam logic [SPEED_W-1:0] SPEED_MATCH_DEF = 16'h000a;
    localparam logic [POS_W-1:0] POS_DONE_DEF = 32'h0000000a;
    localparam logic [SPEED_W-1:0] ROT_THRESH_DEF = 16'h0014;
    localparam logic [SPEED_W-1:0] TORQUE_PRESET_DEF = 16'h000a;

    // ==========================================================
    // Power-up wait before the status view appears
    localparam int STARTUP_WAIT_US = 1000;
    localparam int CLK_MHZ = 125;
    localparam int STARTUP_CYCLES = STARTUP_WAIT_US * CLK_MHZ;

    // Digit positions while editing (0 is rightmost)
    localparam logic [2:0] DIGIT_LAST = 3'h4;
    localparam logic [2:0] DIGIT_FIRST = 3'h0;

    // ==========================================================
    // Basic modes, stepped in this order by the mode key
    typedef enum logic [1:0] {
        MODE_STATUS,
        MODE_UTILITY,
        MODE_PARAM,
        MODE_MONITOR
    } spsd_mode_t;

    // Operating state codes shown in the three right digits
    typedef enum logic [3:0] {
        CODE_INIT_FAIL,
        CODE_SERVO_OFF,
        CODE_READY,
        CODE_RUN,
        CODE_QUICK_STOP,
        CODE_ALARM,
        CODE_SAFE,
        CODE_FWD_PROHIB,
        CODE_REV_PROHIB,
        CODE_OVERTRAVEL,
        CODE_ALARM_NUM
    } spsd_code_t;

    // Drive status inputs
    typedef struct packed {
        logic initFail;
        logic servoOn;
        logic servoReady;
        logic quickStop;
        logic alarm;
        logic showAlarmNum;
        logic safeState;
        logic fwdProhibit;
        logic revProhibit;
        logic ctrlPower;
        logic mainPowerOk;
        logic posMode;
        logic torqueMode;
        logic refPulseActive;
        logic devClear;
    } spsd_status_t;

    // Signed measured quantities
    typedef struct packed {
        logic signed [SPEED_W-1:0] motorSpeed;
        logic signed [SPEED_W-1:0] speedRef;
        logic signed [SPEED_W-1:0] torqueRef;
        logic signed [POS_W-1:0] posError;
    } spsd_meas_t;

    // Threshold parameters
    typedef struct packed {
        logic [SPEED_W-1:0] speedMatchWindow;
        logic [POS_W-1:0] positionDoneWindow;
        logic [SPEED_W-1:0] rotationSpeedThreshold;
        logic [SPEED_W-1:0] torquePreset;
    } spsd_thresh_t;

    // One-cycle key press pulses
    typedef struct packed {
        logic mode;
        logic up;
        logic down;
        logic dataSet;
    } spsd_keys_t;

endpackage

//--- hdl/spsd_seg_eval.sv
// Purpose: evaluate the seven bit-data segments from drive state
// Assumes: inputs stable within a clock, thresholds unsigned
// Notes: output registered, one cycle after inputs
`timescale 1ns/1ps
module spsd_seg_eval (
    input wire logic mclk,
    input wire logic rstn,
    input wire spsd_pkg::spsd_status_t st,
    input wire spsd_pkg::spsd_meas_t meas,
    input wire spsd_pkg::spsd_thresh_t th,
    output logic [6:0] segs_r
);
    logic [spsd_pkg::SPEED_W-1:0] absSpeed;
    logic [spsd_pkg::SPEED_W-1:0] absRef;
    logic [spsd_pkg::SPEED_W-1:0] absTrq;
    logic [spsd_pkg::SPEED_W:0] diff;
    logic [spsd_pkg::SPEED_W:0] absDiff;
    logic [spsd_pkg::POS_W-1:0] absPos;
    logic [6:0] segsNxt;

    always_comb begin
        absSpeed = meas.motorSpeed[spsd_pkg::SPEED_W-1] ? -meas.motorSpeed : meas.motorSpeed;
        absRef = meas.speedRef[spsd_pkg::SPEED_W-1] ? -meas.speedRef : meas.speedRef;
        absTrq = meas.torqueRef[spsd_pkg::SPEED_W-1] ? -meas.torqueRef : meas.torqueRef;
        absPos = meas.posError[spsd_pkg::POS_W-1] ? -meas.posError : meas.posError;
        // Extra bit avoids overflow of the speed difference
        diff = {meas.motorSpeed[spsd_pkg::SPEED_W-1], meas.motorSpeed}
            - {meas.speedRef[spsd_pkg::SPEED_W-1], meas.speedRef};
        absDiff = diff[spsd_pkg::SPEED_W] ? -diff : diff;
        segsNxt = '0;
        if (st.posMode) begin
            segsNxt[0] = absPos < th.positionDoneWindow;
            segsNxt[3] = st.refPulseActive;
            segsNxt[4] = st.devClear;
        end else begin
            segsNxt[0] = st.torqueMode
                || (absDiff <= {1'b0, th.speedMatchWindow});
            segsNxt[3] = absRef > th.rotationSpeedThreshold;
            segsNxt[4] = absTrq > th.torquePreset;
        end
        segsNxt[1] = !st.servoOn;
        segsNxt[2] = st.ctrlPower;
        segsNxt[5] = st.mainPowerOk;
        segsNxt[6] = absSpeed > th.rotationSpeedThreshold;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            segs_r <= '0;
        end else begin
            segs_r <= segsNxt;
        end
    end

    property p_servo_off_seg;
        @(posedge mclk) disable iff (!rstn) 1'b1 |=> segs_r[1] == !$past(st.servoOn);
    endproperty
    a_servo_off_seg: assert property (p_servo_off_seg) else $error("servo off segment wrong");

    property p_ctrl_seg;
        @(posedge mclk) disable iff (!rstn) 1'b1 |=> segs_r[2] == $past(st.ctrlPower);
    endproperty
    a_ctrl_seg: assert property (p_ctrl_seg) else $error("control power segment wrong");

    property p_power_seg;
        @(posedge mclk) disable iff (!rstn) 1'b1 |=> segs_r[5] == $past(st.mainPowerOk);
    endproperty
    a_power_seg: assert property (p_power_seg) else $error("power ready segment wrong");

    property p_torque_seg1;
        @(posedge mclk) disable iff (!rstn) (!st.posMode && st.torqueMode) |=> segs_r[0];
    endproperty
    a_torque_seg1: assert property (p_torque_seg1) else $error("segment 1 dark in torque");

    property p_pos_seg5;
        @(posedge mclk) disable iff (!rstn) st.posMode |=> segs_r[4] == $past(st.devClear);
    endproperty
    a_pos_seg5: assert property (p_pos_seg5) else $error("clear segment wrong");

    property p_rot_seg;
        @(posedge mclk) disable iff (!rstn)
            (absSpeed > th.rotationSpeedThreshold) |=> segs_r[6];
    endproperty
    a_rot_seg: assert property (p_rot_seg) else $error("rotation segment dark");

    property p_pos_seg1;
        @(posedge mclk) disable iff (!rstn)
            (st.posMode && absPos >= th.positionDoneWindow) |=> !segs_r[0];
    endproperty
    a_pos_seg1: assert property (p_pos_seg1) else $error("position done lit early");

    property p_pos_seg4;
        @(posedge mclk) disable iff (!rstn) st.posMode |=> segs_r[3] == $past(st.refPulseActive);
    endproperty
    a_pos_seg4: assert property (p_pos_seg4) else $error("pulse segment wrong");

endmodule // spsd_seg_eval

//--- tb/tb.sv
// Purpose: self-checking bench for the servo panel key handling and status view
// Assumes: short power-up wait via parameter, keys are one-cycle pulses
// Notes: inputs change on the falling edge, outputs are judged on a later falling edge
`timescale 1ns/1ps
module tb;
    localparam int WAIT_CYC = 8;
    logic mclk;
    logic rstn;
    spsd_pkg::spsd_keys_t keys;
    spsd_pkg::spsd_status_t st;
    spsd_pkg::spsd_meas_t meas;
    logic threshLoad;
    spsd_pkg::spsd_thresh_t threshIn;
    logic [15:0] loadValue;
    logic [11:0] alarmNumber;
    logic displayOn;
    spsd_pkg::spsd_mode_t mode;
    logic editing;
    logic [2:0] activeDigit;
    logic [15:0] editValue;
    logic [6:0] bitSegs;
    spsd_pkg::spsd_code_t stateCode;
    logic [11:0] alarmShown;
    logic alarmClearReq;
    spsd_pkg::spsd_thresh_t thresh;
    int badCount;
    int samplesChecked;

    spsd_panel #(.STARTUP_CYCLES(WAIT_CYC)) i_spsd_panel (
        .mclk(mclk), .rstn(rstn), .keys(keys), .st(st), .meas(meas),
        .threshLoad(threshLoad), .threshIn(threshIn), .loadValue(loadValue),
        .alarmNumber(alarmNumber), .displayOn(displayOn), .mode(mode),
        .editing(editing), .activeDigit(activeDigit), .editValue(editValue),
        .bitSegs(bitSegs), .stateCode(stateCode), .alarmShown(alarmShown),
        .alarmClearReq(alarmClearReq), .thresh(thresh)
    );

    // ==========================================================
    // Clock and shared tasks
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic cyc();
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // Idle edge first, so back-to-back presses never drive keys twice in one step
    task automatic press(input spsd_pkg::spsd_keys_t k);
        cyc();
        keys = k;
        cyc();
        keys = '0;
    endtask

    task automatic segChk(input logic [15:0] ms, input logic [15:0] sr, input logic [15:0] tr,
                          input logic [31:0] pe, input logic [6:0] exp);
        meas.motorSpeed = ms;
        meas.speedRef = sr;
        meas.torqueRef = tr;
        meas.posError = pe;
        repeat (2) cyc();
        chk(bitSegs, exp, "segments");
    endtask

    task automatic codeChk(input spsd_pkg::spsd_code_t exp);
        repeat (2) cyc();
        chk(stateCode, exp, "state code");
    endtask

    task automatic endSim();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic resetPhase();
        rstn = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        chk(thresh, {spsd_pkg::SPEED_MATCH_DEF, spsd_pkg::POS_DONE_DEF,
            spsd_pkg::ROT_THRESH_DEF, spsd_pkg::TORQUE_PRESET_DEF}, "default thresholds");
        chk(stateCode, spsd_pkg::CODE_SERVO_OFF, "reset code");
        rstn = 1'b1;
        repeat (3) cyc();
        keys.mode = 1'b1;
        cyc();
        keys = '0;
        repeat (3) cyc();
        chk(displayOn, 1'b0, "display before wait");
        cyc();
        chk(displayOn, 1'b1, "display after wait");
        chk(mode, spsd_pkg::MODE_STATUS, "start mode, early key ignored");
    endtask

    task automatic modeCycle();
        press(4'h8);
        chk(mode, spsd_pkg::MODE_UTILITY, "mode 1");
        press(4'h8);
        chk(mode, spsd_pkg::MODE_PARAM, "mode 2");
        press(4'h8);
        chk(mode, spsd_pkg::MODE_MONITOR, "mode 3");
        press(4'h8);
        chk(mode, spsd_pkg::MODE_STATUS, "mode wrap");
    endtask

    task automatic editWalk();
        press(4'h4);
        chk(editValue, 16'h0000, "up ignored in status view");
        press(4'h8);
        press(4'h8);
        press(4'h1);
        chk({editing, activeDigit, editValue}, {1'b1, 3'h0, 16'h1234}, "open value");
        press(4'h4);
        chk(editValue, 16'h1235, "up digit 0");
        press(4'h2);
        press(4'h2);
        chk(editValue, 16'h1233, "down digit 0");
        press(4'h1);
        chk(activeDigit, 3'h1, "shift left");
        press(4'h4);
        chk(editValue, 16'h123d, "up digit 1");
        press(4'h6);
        chk(editValue, 16'h123d, "up and down together");
        press(4'h1);
        press(4'h1);
        press(4'h1);
        chk(activeDigit, 3'h4, "leftmost digit");
        press(4'h4);
        chk(editValue, 16'h394d, "up digit 4");
        press(4'h2);
        press(4'h2);
        chk(editValue, 16'heb2d, "down digit 4 wraps");
        press(4'h1);
        chk(activeDigit, 3'h0, "digit wraps");
        press(4'h8);
        press(4'h8);
        chk({editing, mode}, {1'b0, spsd_pkg::MODE_STATUS}, "mode key closes edit");
    endtask

    task automatic segScenarios();
        segChk(16'h006e, 16'h0064, 16'h000a, 32'h0, 7'h4f);
        st.servoOn = 1'b1;
        st.ctrlPower = 1'b0;
        st.mainPowerOk = 1'b1;
        segChk(16'h0014, 16'h001f, 16'h000b, 32'h0, 7'h38);
        st.torqueMode = 1'b1;
        st.ctrlPower = 1'b1;
        st.mainPowerOk = 1'b0;
        segChk(16'h01f4, 16'h0000, 16'h0000, 32'h0, 7'h45);
        st.posMode = 1'b1;
        st.torqueMode = 1'b0;
        st.servoOn = 1'b0;
        st.mainPowerOk = 1'b1;
        st.refPulseActive = 1'b1;
        st.devClear = 1'b1;
        segChk(16'h0015, 16'h0000, 16'h0064, 32'hfffffff6, 7'h7e);
        segChk(16'h0015, 16'h0000, 16'h0064, 32'h00000009, 7'h7f);
        st.refPulseActive = 1'b0;
        st.devClear = 1'b0;
        segChk(16'h0015, 16'h0000, 16'h0064, 32'h0000000a, 7'h66);
    endtask

    task automatic threshScenario();
        threshIn = {16'h0014, 32'h00000064, 16'h0258, 16'h0032};
        threshLoad = 1'b1;
        cyc();
        threshLoad = 1'b0;
        chk(thresh, threshIn, "loaded thresholds");
        st.posMode = 1'b0;
        st.servoOn = 1'b1;
        // Under the defaults this case would light segments 4, 5 and 7 and not 1
        segChk(16'h01f4, 16'h0203, 16'h0028, 32'h0, 7'h25);
    endtask

    task automatic codeScenario();
        st = '0;
        codeChk(spsd_pkg::CODE_SERVO_OFF);
        st.servoReady = 1'b1;
        codeChk(spsd_pkg::CODE_READY);
        st.servoOn = 1'b1;
        codeChk(spsd_pkg::CODE_RUN);
        st.revProhibit = 1'b1;
        codeChk(spsd_pkg::CODE_REV_PROHIB);
        st.fwdProhibit = 1'b1;
        codeChk(spsd_pkg::CODE_OVERTRAVEL);
        st.revProhibit = 1'b0;
        codeChk(spsd_pkg::CODE_FWD_PROHIB);
        st.quickStop = 1'b1;
        codeChk(spsd_pkg::CODE_QUICK_STOP);
        st.safeState = 1'b1;
        codeChk(spsd_pkg::CODE_SAFE);
        st.alarm = 1'b1;
        codeChk(spsd_pkg::CODE_ALARM);
        chk(alarmShown, 12'h2a5, "alarm number shown");
        press(4'h1);
        chk(alarmClearReq, 1'b1, "alarm clear request");
        cyc();
        chk(alarmClearReq, 1'b0, "alarm clear is one pulse");
        st.showAlarmNum = 1'b1;
        codeChk(spsd_pkg::CODE_ALARM_NUM);
        st.initFail = 1'b1;
        codeChk(spsd_pkg::CODE_INIT_FAIL);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        badCount = 0;
        samplesChecked = 0;
        rstn = 1'b0;
        keys = '0;
        st = '0;
        st.ctrlPower = 1'b1;
        meas = '0;
        threshLoad = 1'b0;
        threshIn = '0;
        loadValue = 16'h1234;
        alarmNumber = 12'h2a5;
        @(negedge mclk);
        resetPhase();
        modeCycle();
        editWalk();
        segScenarios();
        threshScenario();
        codeScenario();
        endSim();
    end

    // Whole run is just over a hundred cycles; this limit only cuts a hang short
    initial begin
        repeat (3000) @(posedge mclk);
        badCount++;
        endSim();
    end
endmodule // tb
